// ### hdl/agdc_pkg.sv
// ----------------------------------------
// adaptive gate drive control constants
// ----------------------------------------
package agdc_pkg;
  // register byte offsets
  localparam logic [7:0] GEN_OFF = 8'h00;
  localparam logic [7:0] PWMEN_OFF = 8'h04;
  localparam logic [7:0] TON_OFF = 8'h08;
  localparam logic [7:0] TOFF_OFF = 8'h0C;
  localparam logic [7:0] IMAX_OFF = 8'h10;
  localparam logic [7:0] TPRE_OFF = 8'h14;
  localparam logic [7:0] PCI_OFF = 8'h18;
  localparam logic [7:0] PDI_OFF = 8'h1C;
  localparam logic [7:0] ICFG_OFF = 8'h20;
  localparam logic [7:0] STAT_OFF = 8'h24;
  localparam logic [7:0] STAT_LAST = 8'h30;
  // general control fields
  localparam int AGS_LSB = 0;
  localparam int FILT_BIT = 2;
  localparam int STEP_BIT = 3;
  localparam int HOLD_BIT = 4;
  // gate current config fields
  localparam int CHG_LSB = 0;
  localparam int DCHG_LSB = 8;
  localparam int FW_LSB = 16;
  // status fields
  localparam int TON_LSB = 0;
  localparam int TOFF_LSB = 8;
  localparam int PC_LSB = 16;
  localparam int PD_LSB = 24;
  // reset values
  localparam logic [31:0] GEN_RST = 32'h0000_0000;
  localparam logic [31:0] TGT_RST = 32'h1010_1010;
  localparam logic [31:0] IMAX_RST = 32'h1010_1010;
  localparam logic [31:0] TPRE_RST = 32'h4444_4444;
  localparam logic [31:0] INIT_RST = 32'h0808_0808;
  localparam logic [31:0] ICFG_RST = 32'h0008_3F08;
  // current codes
  localparam logic [5:0] MIN_STEP = 6'h01; // 0.5 mA floor
  localparam logic [5:0] HARD_OFF = 6'h3F; // code 63
  localparam logic [5:0] HOLD_LO = 6'h01;
  localparam logic [5:0] HOLD_HI = 6'h04;
  // per-bridge phase
  typedef enum logic [2:0] {
    ST_OFF = 3'b000, ST_PCHG = 3'b001, ST_CHG = 3'b010,
    ST_ON = 3'b011, ST_PDCHG = 3'b100, ST_DCHG = 3'b101
  } agdc_state_type;
endpackage : agdc_pkg

// ### hdl/agdc_bridge.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// one half-bridge phase sequencer
// ----------------------------------------
module agdc_bridge (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // synchronised pins
  input wire logic pwm,
  input wire logic switched,
  // configuration
  input wire logic enable,
  input wire logic [1:0] mode,
  input wire logic filt,
  input wire logic step2,
  input wire logic hold_sel,
  input wire logic [7:0] ton_tgt,
  input wire logic [7:0] toff_tgt,
  input wire logic [5:0] imax,
  input wire logic [5:0] pc_init,
  input wire logic [5:0] pd_init,
  input wire logic [3:0] pc_dur,
  input wire logic [3:0] pd_dur,
  input wire logic [5:0] i_chg,
  input wire logic [5:0] i_dchg,
  input wire logic [5:0] i_fw,
  // gate drive and status
  output logic [5:0] gate_code,
  output logic gate_sink,
  output logic [5:0] fw_code,
  output logic fw_sink,
  output logic [7:0] ton_meas,
  output logic [7:0] toff_meas,
  output logic [5:0] pc_cur,
  output logic [5:0] pd_cur
);
  agdc_pkg::agdc_state_type st_reg;
  agdc_pkg::agdc_state_type st_next;
  logic [7:0] cnt_reg;
  logic [3:0] dur_reg;
  logic pwm_d_reg;
  logic en_d_reg;
  logic [1:0] hon_reg; // last turn-on compare: {longer, shorter}
  logic [1:0] hoff_reg;
  logic adapt_on;
  logic lon, son, loff, soff;
  logic [5:0] lvl_next;
  logic sink_next;

  // step toward target, clamped to the floor and the bridge maximum
  function automatic logic [5:0] adapt(input logic [5:0] cur, input logic up, input logic dn,
                                       input logic two, input logic [5:0] lim);
    logic [6:0] s;
    logic [6:0] st;
    st = two ? 7'h02 : 7'h01; // [RULE20]
    s = {1'b0, cur};
    if (up) begin
      s = s + st;
    end else if (dn) begin
      s = (s > st) ? s - st : 7'h00;
    end
    if (s > {1'b0, lim}) s = {1'b0, lim};
    if (s < {1'b0, agdc_pkg::MIN_STEP}) s = {1'b0, agdc_pkg::MIN_STEP}; // [RULE6] [RULE7]
    return s[5:0];
  endfunction : adapt

  assign adapt_on = mode[1]; // [RULE1]
  assign lon = cnt_reg > ton_tgt;
  assign son = cnt_reg < ton_tgt;
  assign loff = cnt_reg > toff_tgt;
  assign soff = cnt_reg < toff_tgt;

  // phase sequencing from pwm edges and the switch comparator
  always_comb begin
    st_next = st_reg;
    if (!enable) begin
      st_next = agdc_pkg::ST_OFF;
    end else begin
      case (st_reg)
        agdc_pkg::ST_OFF: begin
          if (pwm && !pwm_d_reg) st_next = (mode == 2'b00) ? agdc_pkg::ST_CHG : agdc_pkg::ST_PCHG;
        end
        agdc_pkg::ST_PCHG: begin
          if (!pwm) st_next = agdc_pkg::ST_PDCHG;
          else if (dur_reg <= 4'h1) st_next = agdc_pkg::ST_CHG; // [RULE9]
        end
        agdc_pkg::ST_CHG: begin
          if (!pwm) st_next = agdc_pkg::ST_PDCHG;
          else if (switched) st_next = agdc_pkg::ST_ON;
        end
        agdc_pkg::ST_ON: begin
          if (!pwm) st_next = (mode == 2'b00) ? agdc_pkg::ST_DCHG : agdc_pkg::ST_PDCHG;
        end
        agdc_pkg::ST_PDCHG: begin
          if (dur_reg <= 4'h1) st_next = agdc_pkg::ST_DCHG;
        end
        agdc_pkg::ST_DCHG: begin
          if (!switched) st_next = agdc_pkg::ST_OFF;
        end
        default: st_next = agdc_pkg::ST_OFF;
      endcase
    end
  end

  // active gate current and direction for the next phase
  always_comb begin
    lvl_next = agdc_pkg::HARD_OFF; // [RULE15]
    sink_next = 1'b1;
    if (enable) begin
      case (st_next)
        agdc_pkg::ST_PCHG: begin
          lvl_next = adapt_on ? pc_cur : pc_init; // [RULE5]
          sink_next = 1'b0;
        end
        agdc_pkg::ST_CHG: begin
          lvl_next = i_chg; // [RULE12]
          sink_next = 1'b0;
        end
        agdc_pkg::ST_ON: begin
          lvl_next = hold_sel ? agdc_pkg::HOLD_HI : agdc_pkg::HOLD_LO; // [RULE16]
          sink_next = 1'b0;
        end
        agdc_pkg::ST_PDCHG: lvl_next = adapt_on ? pd_cur : pd_init; // [RULE8]
        agdc_pkg::ST_DCHG: lvl_next = i_dchg; // [RULE13]
        default: lvl_next = hold_sel ? agdc_pkg::HOLD_HI : agdc_pkg::HOLD_LO; // [RULE16]
      endcase
    end
  end

  // state, edge memories and drive registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= agdc_pkg::ST_OFF;
      pwm_d_reg <= 1'b0;
      en_d_reg <= 1'b0;
      gate_code <= agdc_pkg::HARD_OFF;
      gate_sink <= 1'b1;
      fw_code <= agdc_pkg::HARD_OFF;
      fw_sink <= 1'b1;
    end else begin
      st_reg <= st_next;
      pwm_d_reg <= pwm;
      en_d_reg <= enable;
      gate_code <= lvl_next;
      gate_sink <= sink_next;
      fw_code <= enable ? i_fw : agdc_pkg::HARD_OFF; // [RULE14]
      fw_sink <= !(enable && st_next == agdc_pkg::ST_OFF);
    end
  end

  // phase timer and delay counter; delay counts from the start of the turn edge
  always_ff @(posedge clk) begin
    if (reset) begin
      dur_reg <= 4'h0;
      cnt_reg <= 8'h00;
    end else begin
      if (st_next == agdc_pkg::ST_PCHG && st_reg != agdc_pkg::ST_PCHG) dur_reg <= pc_dur; // [RULE9]
      else if (st_next == agdc_pkg::ST_PDCHG && st_reg != agdc_pkg::ST_PDCHG) dur_reg <= pd_dur; // [RULE8]
      else if (dur_reg != 4'h0) dur_reg <= dur_reg - 4'h1;
      if (st_next != st_reg && (st_reg == agdc_pkg::ST_OFF || st_reg == agdc_pkg::ST_ON)) cnt_reg <= 8'h01;
      else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01; // saturates on a stuck gate
    end
  end

  // measured delays and adaptive currents
  always_ff @(posedge clk) begin
    if (reset) begin
      ton_meas <= 8'h00;
      toff_meas <= 8'h00;
      hon_reg <= 2'b00;
      hoff_reg <= 2'b00;
      pc_cur <= agdc_pkg::MIN_STEP;
      pd_cur <= agdc_pkg::MIN_STEP;
    end else if (enable && !en_d_reg) begin
      pc_cur <= (pc_init < imax) ? pc_init : imax; // [RULE17] [RULE10]
      pd_cur <= (pd_init < imax) ? pd_init : imax; // [RULE17] [RULE11]
      hon_reg <= 2'b00;
      hoff_reg <= 2'b00;
    end else begin
      if (st_reg == agdc_pkg::ST_CHG && st_next == agdc_pkg::ST_ON) begin
        ton_meas <= cnt_reg; // [RULE4]
        hon_reg <= {lon, son};
        if (adapt_on) begin
          pc_cur <= adapt(pc_cur, lon && (!filt || hon_reg[1]), son && (!filt || hon_reg[0]),
                          step2, imax); // [RULE2] [RULE18] [RULE19] [RULE21]
        end
      end
      if (st_reg == agdc_pkg::ST_DCHG && st_next == agdc_pkg::ST_OFF) begin
        toff_meas <= cnt_reg; // [RULE4]
        hoff_reg <= {loff, soff};
        if (adapt_on) begin
          pd_cur <= adapt(pd_cur, loff && (!filt || hoff_reg[1]), soff && (!filt || hoff_reg[0]),
                          step2, imax); // [RULE2] [RULE18] [RULE19] [RULE21]
        end
      end
    end
  end
endmodule : agdc_bridge
`default_nettype wire

// ### hdl/agdc_top.sv
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// adaptive gate drive control, four half-bridges
// ----------------------------------------
// What this block does
// RULE1: adapt only when gate select is 10 or 11
// RULE2: steer currents toward target on/off delays
// RULE3: separate turn-on and turn-off target registers
// RULE4: report measured delays per half-bridge
// RULE5: source pre-charge current for programmed duration
// RULE6: clamp pre-charge current floor to maximum
// RULE7: clamp pre-discharge current floor to maximum
// RULE8: sink pre-discharge current for programmed duration
// RULE9: pre-charge duration programmable per bridge
// RULE10: pre-charge starts from its initial setting
// RULE11: pre-discharge starts from its own initial setting
// RULE12: charge phase uses configured charge current
// RULE13: discharge phase sinks configured discharge current
// RULE14: freewheel switch uses its own current
// RULE15: hard-off equals discharge code 63
// RULE16: hold current level picked by control bit
// RULE17: on enable load min of initial, maximum
// RULE18: unfiltered: longer raises, shorter lowers current
// RULE19: filtered: change only after two agreeing cycles
// RULE20: step bit chooses one or two steps
// RULE21: each bridge keeps independent adaptive state
module agdc_top #(
  parameter int NUM_HB = 4
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pwm and switch comparator pins
  input wire logic [NUM_HB-1:0] PWM_INPUT_PIN,
  input wire logic [NUM_HB-1:0] GATE_SWITCHED,
  // active gate drive, six-bit current code per bridge
  output logic [6*NUM_HB-1:0] GATE_CURRENT,
  output logic [NUM_HB-1:0] GATE_SINK,
  // freewheel gate drive
  output logic [6*NUM_HB-1:0] FW_CURRENT,
  output logic [NUM_HB-1:0] FW_SINK
);
  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [31:0] general_control_reg;
  logic [31:0] pwm_enable_reg;
  logic [31:0] turn_on_target_reg;
  logic [31:0] turn_off_target_reg;
  logic [31:0] max_drive_current_reg;
  logic [31:0] precharge_timing_reg;
  logic [31:0] precharge_initial_reg;
  logic [31:0] predischarge_initial_reg;
  logic [31:0] gate_current_config_reg;
  logic [31:0] rdata_next;
  logic err_next;
  logic wr_en;
  logic [1:0] adaptive_gate_select;
  logic adaptation_filter_bit;
  logic adaptation_step_size_bit;
  logic hold_current_select;
  logic [NUM_HB-1:0] bridge_pwm_enable;
  logic [5:0] charge_phase_current;
  logic [5:0] discharge_phase_current;
  logic [5:0] freewheel_drive_current;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NUM_HB-1:0] pwm_meta_reg;
  logic [NUM_HB-1:0] pwm_sync_reg;
  logic [NUM_HB-1:0] sw_meta_reg;
  logic [NUM_HB-1:0] sw_sync_reg;

  // per-bridge status
  logic [7:0] ton_meas [NUM_HB];
  logic [7:0] toff_meas [NUM_HB];
  logic [5:0] pc_cur [NUM_HB];
  logic [5:0] pd_cur [NUM_HB];

  // pins come from the gate stage asynchronously, so two stages before use
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pwm_meta_reg <= '0;
      pwm_sync_reg <= '0;
      sw_meta_reg <= '0;
      sw_sync_reg <= '0;
    end else begin
      pwm_meta_reg <= PWM_INPUT_PIN;
      pwm_sync_reg <= pwm_meta_reg;
      sw_meta_reg <= GATE_SWITCHED;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  // mode and adaptation controls shared by all bridges
  assign adaptive_gate_select = general_control_reg[agdc_pkg::AGS_LSB +: 2];
  assign adaptation_filter_bit = general_control_reg[agdc_pkg::FILT_BIT];
  assign adaptation_step_size_bit = general_control_reg[agdc_pkg::STEP_BIT];
  assign hold_current_select = general_control_reg[agdc_pkg::HOLD_BIT];
  assign bridge_pwm_enable = pwm_enable_reg[NUM_HB-1:0];
  assign charge_phase_current = gate_current_config_reg[agdc_pkg::CHG_LSB +: 6];
  assign discharge_phase_current = gate_current_config_reg[agdc_pkg::DCHG_LSB +: 6];
  assign freewheel_drive_current = gate_current_config_reg[agdc_pkg::FW_LSB +: 6];

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // no wait state: ready is registered so the answer comes from a flop
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

  // read decode, unmapped addresses answer with an error and zero data
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (PADDR == agdc_pkg::GEN_OFF) begin
      rdata_next = general_control_reg;
    end else if (PADDR == agdc_pkg::PWMEN_OFF) begin
      rdata_next = pwm_enable_reg;
    end else if (PADDR == agdc_pkg::TON_OFF) begin
      rdata_next = turn_on_target_reg;
    end else if (PADDR == agdc_pkg::TOFF_OFF) begin
      rdata_next = turn_off_target_reg;
    end else if (PADDR == agdc_pkg::IMAX_OFF) begin
      rdata_next = max_drive_current_reg;
    end else if (PADDR == agdc_pkg::TPRE_OFF) begin
      rdata_next = precharge_timing_reg;
    end else if (PADDR == agdc_pkg::PCI_OFF) begin
      rdata_next = precharge_initial_reg;
    end else if (PADDR == agdc_pkg::PDI_OFF) begin
      rdata_next = predischarge_initial_reg;
    end else if (PADDR == agdc_pkg::ICFG_OFF) begin
      rdata_next = gate_current_config_reg;
    end else if (PADDR >= agdc_pkg::STAT_OFF && PADDR <= agdc_pkg::STAT_LAST && PADDR[1:0] == 2'b00) begin
      for (int i = 0; i < NUM_HB; i++) begin
        if (PADDR == agdc_pkg::STAT_OFF + 8'(4 * i)) begin
          rdata_next[agdc_pkg::TON_LSB +: 8] = ton_meas[i]; // [RULE4]
          rdata_next[agdc_pkg::TOFF_LSB +: 8] = toff_meas[i]; // [RULE4]
          rdata_next[agdc_pkg::PC_LSB +: 6] = pc_cur[i];
          rdata_next[agdc_pkg::PD_LSB +: 6] = pd_cur[i];
        end
      end
    end else begin
      err_next = 1'b1;
    end
  end

  // answer registers; writes to status or unmapped words are dropped
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
        PSLVERR <= err_next;
      end else begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // control and target registers, written only on the completing apb edge
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      general_control_reg <= agdc_pkg::GEN_RST;
      pwm_enable_reg <= agdc_pkg::GEN_RST;
      turn_on_target_reg <= agdc_pkg::TGT_RST;
      turn_off_target_reg <= agdc_pkg::TGT_RST;
    end else if (wr_en) begin
      if (PADDR == agdc_pkg::GEN_OFF) begin
        general_control_reg <= {27'h0, PWDATA[4:0]}; // [RULE1] [RULE16]
      end else if (PADDR == agdc_pkg::PWMEN_OFF) begin
        pwm_enable_reg <= {28'h000_0000, PWDATA[3:0]}; // [RULE17]
      end else if (PADDR == agdc_pkg::TON_OFF) begin
        turn_on_target_reg <= PWDATA; // [RULE3]
      end else if (PADDR == agdc_pkg::TOFF_OFF) begin
        turn_off_target_reg <= PWDATA; // [RULE3]
      end
    end
  end

  // current limits, timings and start values
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      max_drive_current_reg <= agdc_pkg::IMAX_RST;
      precharge_timing_reg <= agdc_pkg::TPRE_RST;
      precharge_initial_reg <= agdc_pkg::INIT_RST;
      predischarge_initial_reg <= agdc_pkg::INIT_RST;
      gate_current_config_reg <= agdc_pkg::ICFG_RST;
    end else if (wr_en) begin
      if (PADDR == agdc_pkg::IMAX_OFF) begin
        max_drive_current_reg <= PWDATA & 32'h3F3F_3F3F;
      end else if (PADDR == agdc_pkg::TPRE_OFF) begin
        precharge_timing_reg <= PWDATA; // [RULE9]
      end else if (PADDR == agdc_pkg::PCI_OFF) begin
        precharge_initial_reg <= PWDATA & 32'h3F3F_3F3F; // [RULE10]
      end else if (PADDR == agdc_pkg::PDI_OFF) begin
        predischarge_initial_reg <= PWDATA & 32'h3F3F_3F3F; // [RULE11]
      end else if (PADDR == agdc_pkg::ICFG_OFF) begin
        gate_current_config_reg <= PWDATA & 32'h003F_3F3F;
      end
    end
  end

  // ----------------------------------------
  // half-bridge sequencers
  // ----------------------------------------
  // each bridge owns its counters and currents so pwm on one never moves another
  for (genvar g = 0; g < NUM_HB; g++) begin : g_hb
    agdc_bridge u_bridge (
      .clk(SYS_CLK),
      .reset(RESET),
      .pwm(pwm_sync_reg[g]),
      .switched(sw_sync_reg[g]),
      .enable(bridge_pwm_enable[g]),
      .mode(adaptive_gate_select),
      .filt(adaptation_filter_bit),
      .step2(adaptation_step_size_bit),
      .hold_sel(hold_current_select),
      .ton_tgt(turn_on_target_reg[8*g +: 8]),
      .toff_tgt(turn_off_target_reg[8*g +: 8]),
      .imax(max_drive_current_reg[8*g +: 6]),
      .pc_init(precharge_initial_reg[8*g +: 6]),
      .pd_init(predischarge_initial_reg[8*g +: 6]),
      .pc_dur(precharge_timing_reg[8*g +: 4]),
      .pd_dur(precharge_timing_reg[8*g+4 +: 4]),
      .i_chg(charge_phase_current),
      .i_dchg(discharge_phase_current),
      .i_fw(freewheel_drive_current),
      .gate_code(GATE_CURRENT[6*g +: 6]),
      .gate_sink(GATE_SINK[g]),
      .fw_code(FW_CURRENT[6*g +: 6]),
      .fw_sink(FW_SINK[g]),
      .ton_meas(ton_meas[g]),
      .toff_meas(toff_meas[g]),
      .pc_cur(pc_cur[g]),
      .pd_cur(pd_cur[g])
    ); // [RULE21]
  end
endmodule : agdc_top
`default_nettype wire

// ### dv/agdc_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// port checker for the gate drive block
// ----------------------------------------
module agdc_properties #(
  parameter int NUM_HB = 4
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins
  input wire logic [NUM_HB-1:0] PWM_INPUT_PIN,
  input wire logic [6*NUM_HB-1:0] GATE_CURRENT,
  input wire logic [NUM_HB-1:0] GATE_SINK
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // apb answers with no wait state, ready in the first access cycle
  property p_rdy_setup; PSEL && !PENABLE |=> PREADY; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("no ready after setup");
  property p_rdy_cause; PREADY |-> $past(PSEL) && !$past(PENABLE); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without setup");
  property p_rdy_pulse; PREADY |=> !PREADY; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
  property p_err_rdy; PSLVERR |-> PREADY; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_rd_idle; !PREADY |-> PRDATA == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  // reset must leave every active gate output hard off, freewheel not checked; own disable iff (1'b0) so reset does not mask it
  property p_rst_off;
    @(posedge SYS_CLK) disable iff (1'b0)
    $fell(RESET) |-> GATE_SINK == '1 && GATE_CURRENT == {NUM_HB{agdc_pkg::HARD_OFF}};
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("gate not hard off");
  property p_src_floor; !GATE_SINK[0] |-> GATE_CURRENT[5:0] >= agdc_pkg::MIN_STEP; endproperty
  a_src_floor: assert property (p_src_floor) else $error("source below floor");
  property p_snk_floor; GATE_SINK[0] |-> GATE_CURRENT[5:0] >= agdc_pkg::MIN_STEP; endproperty
  a_snk_floor: assert property (p_snk_floor) else $error("sink below floor");
  property p_src_pwm;
    $fell(GATE_SINK[0]) |-> $past(PWM_INPUT_PIN[0], 3) || $past(PWM_INPUT_PIN[0], 4);
  endproperty
  a_src_pwm: assert property (p_src_pwm) else $error("source without pwm");
  c_err: cover property (PSLVERR);
  c_src: cover property ($fell(GATE_SINK[0]));
  c_stat: cover property (PREADY && PRDATA[21:16] != 6'h00);
endmodule : agdc_properties
bind agdc_top agdc_properties #(.NUM_HB(NUM_HB)) i_agdc_properties (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_INPUT_PIN(PWM_INPUT_PIN),
  .GATE_CURRENT(GATE_CURRENT), .GATE_SINK(GATE_SINK));
`default_nettype wire

// ### dv/agdc_gate_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// external mosfet gates with threshold comparator
// ----------------------------------------
module agdc_gate_model (
  // clock
  input wire logic clk,
  // gate drive direction
  input wire logic [3:0] gate_sink,
  // cycles of drive needed to cross the threshold
  input wire logic [7:0] dly,
  // comparator back to the block
  output wire logic [3:0] switched
);
  logic [7:0] lvl [4] = '{default: 8'h00};
  logic [3:0] sw = 4'h0;
  assign switched = sw;
  // gate charge integrates drive; hysteresis keeps the comparator from chattering
  always @(posedge clk) begin
    for (int g = 0; g < 4; g++) begin
      if (!gate_sink[g] && lvl[g] < dly) lvl[g] <= lvl[g] + 8'h01;
      else if (gate_sink[g] && lvl[g] != 8'h00) lvl[g] <= lvl[g] - 8'h01;
      if (lvl[g] >= dly) sw[g] <= 1'b1;
      else if (lvl[g] == 8'h00) sw[g] <= 1'b0;
    end
  end
endmodule : agdc_gate_model
`default_nettype wire

// ### dv/agdc_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// testbench top
// ----------------------------------------
module agdc_tb_top;
  logic SYS_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR, dly_cyc;
  logic [31:0] PWDATA, PRDATA;
  logic [3:0] PWM_INPUT_PIN, GATE_SWITCHED, GATE_SINK, FW_SINK;
  logic [23:0] GATE_CURRENT, FW_CURRENT;
  int miscompares = 0;
  int total_checks = 0;
  agdc_top i_agdc_top (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PWM_INPUT_PIN(PWM_INPUT_PIN), .GATE_SWITCHED(GATE_SWITCHED),
    .GATE_CURRENT(GATE_CURRENT), .GATE_SINK(GATE_SINK), .FW_CURRENT(FW_CURRENT), .FW_SINK(FW_SINK));
  agdc_gate_model i_agdc_gate_model (.clk(SYS_CLK), .gate_sink(GATE_SINK), .dly(dly_cyc),
    .switched(GATE_SWITCHED));
  // 25 mhz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; waits for ready, not a fixed count
  task automatic apb(input logic wen, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= wen;
    PADDR <= adr;
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] q;
    logic e;
    apb(1'b1, adr, wd, q, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, adr, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask : rdchk
  // bridge 0 currents, and whether both delays passed target 0x10
  task automatic stat(input logic [5:0] pc, input logic [5:0] pd, input logic lng);
    logic [31:0] q;
    logic e;
    apb(1'b0, agdc_pkg::STAT_OFF, 32'h0000_0000, q, e);
    chk(q & 32'h3F3F_0000, {2'b00, pd, 2'b00, pc, 16'h0000});
    chk({30'b0, q[7:0] > 8'h10, q[15:8] > 8'h10}, {30'b0, lng, lng});
  endtask : stat
  // one pwm period on bridge 0 with gate threshold d cycles away
  task automatic pwm_cycle(input logic [7:0] d, input logic [5:0] hold);
    dly_cyc <= d;
    PWM_INPUT_PIN[0] <= 1'b1;
    for (int i = 0; i < 400 && GATE_SWITCHED[0] !== 1'b1; i++) @(posedge SYS_CLK);
    repeat (8) @(posedge SYS_CLK);
    chk({25'b0, GATE_SINK[0], GATE_CURRENT[5:0]}, {25'b0, 1'b0, hold});
    PWM_INPUT_PIN[0] <= 1'b0;
    for (int i = 0; i < 400 && GATE_SWITCHED[0] !== 1'b0; i++) @(posedge SYS_CLK);
    repeat (8) @(posedge SYS_CLK);
    chk({25'b0, GATE_SINK[0], GATE_CURRENT[5:0]}, {25'b0, 1'b1, hold});
  endtask : pwm_cycle
  task automatic t_reset_values();
    rdchk(agdc_pkg::GEN_OFF, agdc_pkg::GEN_RST);
    rdchk(agdc_pkg::TON_OFF, agdc_pkg::TGT_RST);
    rdchk(agdc_pkg::TOFF_OFF, agdc_pkg::TGT_RST);
    rdchk(agdc_pkg::IMAX_OFF, agdc_pkg::IMAX_RST);
    rdchk(agdc_pkg::TPRE_OFF, agdc_pkg::TPRE_RST);
    rdchk(agdc_pkg::PCI_OFF, agdc_pkg::INIT_RST);
    rdchk(agdc_pkg::PDI_OFF, agdc_pkg::INIT_RST);
    rdchk(agdc_pkg::ICFG_OFF, agdc_pkg::ICFG_RST);
    $display("t_reset_values done");
  endtask : t_reset_values
  // unmapped place errors; status ignores writes
  task automatic t_refused();
    logic [31:0] q;
    logic e;
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
    chk({31'b0, e}, 32'h0000_0001);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk({e, q[30:0]}, 32'h8000_0000);
    apb(1'b0, agdc_pkg::STAT_OFF, 32'h0000_0000, q, e);
    wr(agdc_pkg::STAT_OFF, ~q);
    rdchk(agdc_pkg::STAT_OFF, q);
    $display("t_refused done");
  endtask : t_refused
  // limits 10, starts 12 and 4, targets 16, gate select 10
  task automatic t_adapt();
    wr(agdc_pkg::IMAX_OFF, 32'h0000_000A);
    wr(agdc_pkg::PCI_OFF, 32'h0000_000C);
    wr(agdc_pkg::PDI_OFF, 32'h0000_0004);
    wr(agdc_pkg::GEN_OFF, 32'h0000_0002);
    wr(agdc_pkg::PWMEN_OFF, 32'h0000_0001);
    stat(6'h0A, 6'h04, 1'b0);
    pwm_cycle(8'd40, agdc_pkg::HOLD_LO);
    stat(6'h0A, 6'h05, 1'b1);
    wr(agdc_pkg::GEN_OFF, 32'h0000_000A);
    pwm_cycle(8'd40, agdc_pkg::HOLD_LO);
    stat(6'h0A, 6'h07, 1'b1);
    pwm_cycle(8'd2, agdc_pkg::HOLD_LO);
    stat(6'h08, 6'h05, 1'b0);
    wr(agdc_pkg::GEN_OFF, 32'h0000_000E);
    pwm_cycle(8'd40, agdc_pkg::HOLD_LO);
    stat(6'h08, 6'h05, 1'b1);
    pwm_cycle(8'd40, agdc_pkg::HOLD_LO);
    stat(6'h0A, 6'h07, 1'b1);
    wr(agdc_pkg::GEN_OFF, 32'h0000_0000);
    pwm_cycle(8'd2, agdc_pkg::HOLD_LO);
    stat(6'h0A, 6'h07, 1'b0);
    wr(agdc_pkg::GEN_OFF, 32'h0000_0013);
    pwm_cycle(8'd2, agdc_pkg::HOLD_HI);
    stat(6'h09, 6'h06, 1'b0);
    chk({FW_SINK, GATE_SINK[1], GATE_CURRENT[11:6], FW_CURRENT[11:0]},
      {5'h1D, {2{agdc_pkg::HARD_OFF}}, agdc_pkg::ICFG_RST[21:16]});
    $display("t_adapt done");
  endtask : t_adapt
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    PWM_INPUT_PIN = 4'h0;
    dly_cyc = 8'h02;
    repeat (16) @(posedge SYS_CLK);
    RESET <= 1'b0;
    t_reset_values();
    t_refused();
    t_adapt();
    report_and_stop();
  end
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : agdc_tb_top
`default_nettype wire
